// ===== hdl/sigma_delta_decimation_filter.v
// decimation filters for two sigma-delta modulators with an apb register port
// assumes modulator bits change on the rising edge of mod_clk, which is far slower than sys_clk
`timescale 1ns/1ps
`include "sdflt_defs.vh"

// What this block does
// - the chop bit turns system chopping on, alternating input polarity and undoing it digitally.
// - the pair average bit makes each result the mean of the two latest conversions.
// - while chopping is on the pair average is applied regardless of its bit.
// - pair averaging without chop keeps the output rate but costs one extra conversion of settling.
// - the order bit selects a fourth-order sinc when one and a third-order sinc when zero.
// - the post average field makes a first-order stage summing field plus one sinc outputs.
// - the notch bit adds a second notch at 1.2 times the main notch.
// - the decimation field sets the sinc oversampling ratio and resets to 0x7d.
// - when shared sampling select is zero both converters use the second converter's settings.
module sigma_delta_decimation_filter (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        mod_clk,
  input  wire [1:0]  mod_bit,
  output wire [1:0]  chop_phase
);

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg       tick_prev_q;
  wire      tick;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q     <= 3'h0;
      sync2_q     <= 3'h0;
      tick_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {mod_clk, mod_bit};
      sync2_q     <= sync1_q;
      tick_prev_q <= sync2_q[2];
    end
  end

  assign tick = sync2_q[2] & ~tick_prev_q;

  // ****************************************
  // apb registers
  // ****************************************
  reg  [`CFG_W-1:0] cfg_q [0:1];
  reg               shared_q;
  reg  [31:0]       result_q [0:1];
  reg  [1:0]        ready_q;
  wire [1:0]        new_result;
  wire [31:0]       new_value [0:1];
  wire              wr;
  wire              rd;
  wire              hit;

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign hit     = (paddr == `ADDR_CFG_FIRST) | (paddr == `ADDR_CFG_SECOND) | (paddr == `ADDR_SHARED) |
                   (paddr == `ADDR_RESULT_FIRST) | (paddr == `ADDR_RESULT_SECOND) | (paddr == `ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q[0]    <= `CFG_RESET;
      cfg_q[1]    <= `CFG_RESET;
      shared_q    <= `SHARED_RESET;
      result_q[0] <= 32'h0;
      result_q[1] <= 32'h0;
      ready_q     <= 2'h0;
    end else begin
      if (wr && paddr == `ADDR_CFG_FIRST)
        cfg_q[0] <= pwdata[`CFG_W-1:0] & `CFG_WMASK;
      if (wr && paddr == `ADDR_CFG_SECOND)
        cfg_q[1] <= pwdata[`CFG_W-1:0] & `CFG_WMASK;
      if (wr && paddr == `ADDR_SHARED)
        shared_q <= pwdata[`BIT_SHARED];
      if (new_result[0])
        result_q[0] <= new_value[0];
      if (new_result[1])
        result_q[1] <= new_value[1];
      ready_q[0] <= new_result[0] | (ready_q[0] & ~(rd && paddr == `ADDR_RESULT_FIRST));
      ready_q[1] <= new_result[1] | (ready_q[1] & ~(rd && paddr == `ADDR_RESULT_SECOND));
    end
  end

  always @* begin
    prdata = 32'h0;
    if (rd) begin
      case (paddr)
        `ADDR_CFG_FIRST:     prdata = {16'h0, cfg_q[0]};
        `ADDR_CFG_SECOND:    prdata = {16'h0, cfg_q[1]};
        `ADDR_SHARED:        prdata = {31'h0, shared_q};
        `ADDR_RESULT_FIRST:  prdata = result_q[0];
        `ADDR_RESULT_SECOND: prdata = result_q[1];
        `ADDR_STATUS:        prdata = {30'h0, ready_q};
        default:             prdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // filter channels
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      wire [`CFG_W-1:0] cfg;
      reg  [`CFG_W-1:0] cfg_prev_q;
      wire              flush;
      wire              chop_on;
      wire              pair_on;
      wire              order4;
      wire [6:0]        ratio;
      wire [6:0]        notch_len;
      wire [3:0]        post_n;
      wire signed [`ACC_W-1:0] x;
      wire signed [`ACC_W-1:0] stage_in;
      wire signed [`ACC_W-1:0] c0, c1, c2, c3;
      wire signed [`ACC_W-1:0] sinc_out;
      wire signed [`ACC_W-1:0] post_sum;
      wire signed [`ACC_W-1:0] chopped;
      wire signed [`ACC_W:0]   pair_sum;
      wire signed [`ACC_W-1:0] final_v;
      wire [13:0]       notch_prod;
      reg  [`LINE_W-1:0] line_q;
      reg  signed [`ACC_W-1:0] box_q;
      reg  signed [`ACC_W-1:0] integ_q [0:3];
      reg  signed [`ACC_W-1:0] dly_q [0:3];
      reg  signed [`ACC_W-1:0] acc_q;
      reg  signed [`ACC_W-1:0] prev_q;
      reg  [6:0]        dec_cnt_q;
      reg  [3:0]        post_cnt_q;
      reg  [2:0]        sinc_skip_q;
      reg               pair_skip_q;
      reg               phase_q;
      reg               emit_q;
      reg  [31:0]       out_q;
      integer           k;

      assign cfg       = (ch == 0 && !shared_q) ? cfg_q[1] : cfg_q[0 + ch];
      assign flush     = (cfg != cfg_prev_q);
      assign chop_on   = cfg[`BIT_CHOP];
      assign pair_on   = cfg[`BIT_PAIR_AVG] | chop_on;
      assign order4    = cfg[`BIT_ORDER4];
      assign ratio     = (cfg[`DEC_HI:`DEC_LO] == 7'h0) ? 7'h1 : cfg[`DEC_HI:`DEC_LO];
      assign post_n    = cfg[`POST_HI:`POST_LO];
      assign notch_prod = ratio * `NOTCH_MUL / `NOTCH_DIV;
      assign notch_len = (notch_prod[6:0] == 7'h0) ? 7'h1 : notch_prod[6:0];

      // modulator bit as +1 or -1, or a boxcar of 5/6 ratio for the second notch
      assign x = cfg[`BIT_SECOND_NOTCH_ENABLE] ?
                 box_q + (sync2_q[ch] ? 40'sd1 : -40'sd1) - (line_q[notch_len - 7'h1] ? 40'sd1 : -40'sd1) :
                 (sync2_q[ch] ? 40'sd1 : -40'sd1);

      assign stage_in = order4 ? integ_q[3] : integ_q[2];
      assign c0 = stage_in - dly_q[0];
      assign c1 = c0 - dly_q[1];
      assign c2 = c1 - dly_q[2];
      assign c3 = c2 - dly_q[3];
      assign sinc_out = order4 ? c3 : c2;
      assign post_sum = acc_q + sinc_out;
      assign chopped  = phase_q ? -post_sum : post_sum;
      assign pair_sum = {prev_q[`ACC_W-1], prev_q} + {chopped[`ACC_W-1], chopped};
      assign final_v  = pair_on ? pair_sum[`ACC_W:1] : chopped;

      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          cfg_prev_q  <= `CFG_RESET;
          line_q      <= {`LINE_W{1'b0}};
          box_q       <= 40'sd0;
          acc_q       <= 40'sd0;
          prev_q      <= 40'sd0;
          dec_cnt_q   <= 7'h0;
          post_cnt_q  <= 4'h0;
          sinc_skip_q <= `SKIP_SINC3;
          pair_skip_q <= 1'b0;
          phase_q     <= 1'b0;
          emit_q      <= 1'b0;
          out_q       <= 32'h0;
          for (k = 0; k < 4; k = k + 1) begin
            integ_q[k] <= 40'sd0;
            dly_q[k]   <= 40'sd0;
          end
        end else begin
          cfg_prev_q <= cfg;
          emit_q     <= 1'b0;
          if (flush) begin
            line_q      <= {`LINE_W{1'b0}};
            box_q       <= 40'sd0;
            acc_q       <= 40'sd0;
            prev_q      <= 40'sd0;
            dec_cnt_q   <= 7'h0;
            post_cnt_q  <= 4'h0;
            sinc_skip_q <= order4 ? `SKIP_SINC4 : `SKIP_SINC3;
            pair_skip_q <= pair_on;
            phase_q     <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
              integ_q[k] <= 40'sd0;
              dly_q[k]   <= 40'sd0;
            end
          end else if (tick) begin
            line_q     <= {line_q[`LINE_W-2:0], sync2_q[ch]};
            box_q      <= x;
            integ_q[0] <= integ_q[0] + x;
            for (k = 1; k < 4; k = k + 1)
              integ_q[k] <= integ_q[k] + integ_q[k-1];
            if (dec_cnt_q == ratio - 7'h1) begin
              dec_cnt_q <= 7'h0;
              dly_q[0]  <= stage_in;
              dly_q[1]  <= c0;
              dly_q[2]  <= c1;
              dly_q[3]  <= c2;
              if (sinc_skip_q != 3'h0) begin
                sinc_skip_q <= sinc_skip_q - 3'h1;
              end else if (post_cnt_q == post_n) begin
                post_cnt_q <= 4'h0;
                acc_q      <= 40'sd0;
                phase_q    <= chop_on & ~phase_q;
                prev_q     <= chopped;
                if (pair_skip_q) begin
                  pair_skip_q <= 1'b0;
                end else begin
                  emit_q <= 1'b1;
                  out_q  <= final_v[`ACC_W-1:`OUT_LO];
                end
              end else begin
                post_cnt_q <= post_cnt_q + 4'h1;
                acc_q      <= post_sum;
              end
            end else begin
              dec_cnt_q <= dec_cnt_q + 7'h1;
            end
          end
        end
      end

      assign new_result[ch] = emit_q;
      assign new_value[ch]  = out_q;
      assign chop_phase[ch] = phase_q;
    end
  endgenerate

endmodule

// ===== hdl/sdflt_defs.vh
// constants of the decimation filter block: register map, field layout, reset values
// assumes a 32-bit apb bus with full byte addresses
`ifndef SDFLT_DEFS_VH
`define SDFLT_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CFG_FIRST    32'h40030020
`define ADDR_CFG_SECOND   32'h400300a0
`define ADDR_SHARED       32'h4003001c
`define ADDR_RESULT_FIRST 32'h40030030
`define ADDR_RESULT_SECOND 32'h400300b0
`define ADDR_STATUS       32'h40030034

// ****************************************
// filter configuration fields
// ****************************************
`define CFG_W          16
`define CFG_RESET      16'h007d
`define CFG_WMASK      16'hdfff
`define BIT_CHOP       15
`define BIT_PAIR_AVG   14
`define BIT_ORDER4     12
`define POST_HI        11
`define POST_LO        8
`define BIT_SECOND_NOTCH_ENABLE     7
`define DEC_HI         6
`define DEC_LO         0
`define BIT_SHARED     0
`define SHARED_RESET   1'b0

// ****************************************
// datapath
// ****************************************
`define ACC_W          40
`define OUT_LO         8
`define NOTCH_MUL      8'h05
`define NOTCH_DIV      8'h06
`define LINE_W         128
`define SKIP_SINC3     3'h2
`define SKIP_SINC4     3'h3
`endif

// ===== tb/sdflt_sva.sv
// checker for the decimation filter apb port and chop outputs
// assumes the register map in sdflt_defs.vh; bound to the top module
`timescale 1ns/1ps
`include "sdflt_defs.vh"
module sdflt_sva (
  input wire        sys_clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [1:0]  chop_phase
);
  // ****************
  // register shadows
  // ****************
  logic [15:0] cfg1_q;
  logic [15:0] cfg2_q;
  logic        shr_q;
  wire         acc = psel && penable;
  wire         rd = acc && !pwrite;
  wire         map = paddr == `ADDR_CFG_FIRST || paddr == `ADDR_CFG_SECOND || paddr == `ADDR_SHARED
                     || paddr == `ADDR_RESULT_FIRST || paddr == `ADDR_RESULT_SECOND || paddr == `ADDR_STATUS;
  wire  [15:0] eff1 = shr_q ? cfg1_q : cfg2_q;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg1_q <= `CFG_RESET;
      cfg2_q <= `CFG_RESET;
      shr_q  <= `SHARED_RESET;
    end else if (acc && pwrite) begin
      if (paddr == `ADDR_CFG_FIRST) cfg1_q <= pwdata[15:0] & `CFG_WMASK;
      if (paddr == `ADDR_CFG_SECOND) cfg2_q <= pwdata[15:0] & `CFG_WMASK;
      if (paddr == `ADDR_SHARED) shr_q <= pwdata[0];
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ready_high_a: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  err_flag_a: assert property (acc |-> pslverr == !map)
    else $error("pslverr does not match the address");
  idle_data_a: assert property (!rd |-> prdata == 32'h0)
    else $error("prdata not zero outside a read");
  cfg_first_a: assert property (rd && paddr == `ADDR_CFG_FIRST |-> prdata == {16'h0, cfg1_q})
    else $error("first config reads wrong");
  cfg_second_a: assert property (rd && paddr == `ADDR_CFG_SECOND |-> prdata == {16'h0, cfg2_q})
    else $error("second config reads wrong");
  shared_read_a: assert property (rd && paddr == `ADDR_SHARED |-> prdata == {31'h0, shr_q})
    else $error("shared select reads wrong");
  status_bits_a: assert property (rd && paddr == `ADDR_STATUS |-> prdata[31:2] == 30'h0)
    else $error("status upper bits set");
  chop_first_a: assert property (!(eff1[15] || $past(eff1[15]) || $past(eff1[15], 2) || $past(eff1[15], 3))
    |-> !chop_phase[0]) else $error("first chop phase moves with chop off");
  chop_second_a: assert property (!(cfg2_q[15] || $past(cfg2_q[15]) || $past(cfg2_q[15], 2) || $past(cfg2_q[15], 3))
    |-> !chop_phase[1]) else $error("second chop phase moves with chop off");
endmodule
bind sigma_delta_decimation_filter sdflt_sva chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chop_phase(chop_phase));

// ===== tb/mod_source.sv
// modulator stand-in: sends a given number of bitstream samples
// assumes sys_clk is the block clock; the link clock rests low between bursts
`timescale 1ns/1ps
module mod_source (
  input  wire        sys_clk,
  output logic       mod_clk,
  output logic [1:0] mod_bit
);
  initial begin
    mod_clk = 1'b0;
    mod_bit = 2'b01;
  end
  task automatic send(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      mod_clk <= 1'b1;
      mod_bit <= ~mod_bit;
      repeat (4) @(posedge sys_clk);
      mod_clk <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule

// ===== tb/tb_sigma_delta_decimation_filter.sv
// self-checking bench for the decimation filter: registers and settling counts
// assumes mod_source as the modulator and the checker bound to the design
`timescale 1ns/1ps
`include "sdflt_defs.vh"
module tb_sigma_delta_decimation_filter;
  logic        sys_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         mod_clk;
  wire  [1:0]  mod_bit;
  wire  [1:0]  chop_phase;
  logic [31:0] rdat;
  logic        rerr;
  int          bad_count;
  int          check_count;
  // ratio 4 keeps counts short; order four only at the fast rate; small post average
  logic [15:0] cfg_tab [6] = '{16'h0004, 16'h4004, 16'h8004, 16'hc004, 16'h1004, 16'h0184};
  int          cnt_tab [6] = '{12, 16, 16, 16, 16, 16};
  sigma_delta_decimation_filter dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mod_clk(mod_clk), .mod_bit(mod_bit), .chop_phase(chop_phase));
  mod_source src (.sys_clk(sys_clk), .mod_clk(mod_clk), .mod_bit(mod_bit));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ****************
  // bus and check tasks
  // ****************
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic settle(input logic [31:0] a, input logic [15:0] cfg, input int n, input logic [1:0] rdy);
    apb(1'b0, `ADDR_RESULT_FIRST, 32'h0);
    apb(1'b0, `ADDR_RESULT_SECOND, 32'h0);
    apb(1'b1, a, {16'h0, cfg});
    src.send(n - 1);
    repeat (6) @(posedge sys_clk);
    rd(`ADDR_STATUS, 32'h0);
    chk({30'h0, chop_phase}, {30'h0, rdy & {2{cfg[`BIT_CHOP]}}});
    src.send(1);
    repeat (6) @(posedge sys_clk);
    rd(`ADDR_STATUS, {30'h0, rdy});
    chk({30'h0, chop_phase}, 32'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************
  // test sequence
  // ****************
  initial begin
    bad_count = 0;
    check_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`ADDR_CFG_FIRST, 32'h7d);
    rd(`ADDR_CFG_SECOND, 32'h7d);
    rd(`ADDR_SHARED, 32'h0);
    apb(1'b1, `ADDR_STATUS, 32'h3);
    rd(`ADDR_STATUS, 32'h0);
    apb(1'b0, 32'h40030040, 32'h0);
    chk({rdat[31:1], rerr}, 32'h1);
    apb(1'b1, `ADDR_CFG_FIRST, 32'hffffffff);
    rd(`ADDR_CFG_FIRST, 32'hdfff);
    apb(1'b1, `ADDR_SHARED, 32'hffffffff);
    rd(`ADDR_SHARED, 32'h1);
    for (int i = 0; i < 6; i++)
      settle(`ADDR_CFG_FIRST, cfg_tab[i], cnt_tab[i], 2'b01);
    apb(1'b1, `ADDR_SHARED, 32'h0);
    settle(`ADDR_CFG_SECOND, 16'h0004, 12, 2'b11);
    settle(`ADDR_CFG_SECOND, 16'h8004, 16, 2'b11);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done;
  end
endmodule
